// [rtl/srdc_pkg.sv]
// Constants and types for the switch routing and debug configuration block
package srdc_pkg;
    // Configuration numbers
    localparam logic [7:0]  SRDC_NUM_NODE_ID    = 8'h05;
    localparam logic [7:0]  SRDC_NUM_REF_CLK    = 8'h08;
    localparam logic [7:0]  SRDC_NUM_JTAG_ID    = 8'h09;
    localparam logic [7:0]  SRDC_NUM_USER_CODE  = 8'h0A;
    localparam logic [7:0]  SRDC_NUM_DIR_LOW    = 8'h0C;
    localparam logic [7:0]  SRDC_NUM_DIR_HIGH   = 8'h0D;
    localparam logic [7:0]  SRDC_NUM_DBG_TILE0  = 8'h10;
    localparam logic [7:0]  SRDC_NUM_DBG_TILE1  = 8'h11;
    localparam logic [7:0]  SRDC_NUM_DBG_ORIGIN = 8'h1F;
    localparam logic [7:0]  SRDC_NUM_LINK_BASE  = 8'h20;
    localparam int          SRDC_LINKS          = 8;

    // Reset values
    localparam logic [15:0] SRDC_REF_DIV_RST    = 16'h0003;
    localparam logic [15:0] SRDC_NODE_ID_RST    = 16'h0000;
    localparam logic [31:0] SRDC_DIR_RST        = 32'h0000_0000;

    // Identity words, values arbitrary
    localparam logic [31:0] SRDC_JTAG_ID_WORD   = 32'h1234_5671;
    localparam logic [17:0] SRDC_METAL_ID_CODE  = 18'h0_0A5A;

    // Field positions
    localparam int SRDC_UC_OTP_LSB      = 18;
    localparam int SRDC_DBG_REQ_EN_BIT  = 1;
    localparam int SRDC_DBG_DRV_EN_BIT  = 0;
    localparam int SRDC_ORG_EXT_BIT     = 4;
    localparam int SRDC_ORG_CORE1_BIT   = 1;
    localparam int SRDC_ORG_CORE0_BIT   = 0;
    localparam int SRDC_LS_KIND_LSB     = 24;
    localparam int SRDC_LS_DEST_LSB     = 16;
    localparam int SRDC_LS_DIR_LSB      = 8;
    localparam int SRDC_LS_NET_LSB      = 4;
    localparam int SRDC_LS_JUNK_BIT     = 2;
    localparam int SRDC_LS_DBUSY_BIT    = 1;
    localparam int SRDC_LS_SBUSY_BIT    = 0;

    // Source endpoint kinds
    typedef enum logic [1:0] {
        SRDC_KIND_SWITCH_SIDE_LINK    = 2'b00,
        SRDC_KIND_PROCESSOR_SIDE_LINK = 2'b01,
        SRDC_KIND_SWITCH_CONTROL      = 2'b10,
        SRDC_KIND_UNDEFINED           = 2'b11
    } srdc_kind_t;
endpackage

// [rtl/srdc_route.sv]
// Combinational direction lookup on the most significant identifier mismatch
`timescale 1ns/100ps
module srdc_route
    import srdc_pkg::*;
(
    // Identifiers
    input  wire logic [15:0] node_id_i,
    input  wire logic [15:0] dest_id_i,
    // Direction tables
    input  wire logic [31:0] dir_low_i,
    input  wire logic [31:0] dir_high_i,
    // Decision
    output logic             deliver_local_o,
    output logic [3:0]       direction_o
);
    logic [15:0]  diff;

    function automatic logic [3:0] nibble(input logic [31:0] word, input logic [2:0] idx);
        nibble = word[{idx, 2'b00} +: 4];
    endfunction

    assign diff = node_id_i ^ dest_id_i;

    always_comb begin
        deliver_local_o = (diff == 16'h0000);
        direction_o     = 4'h0;
        for (int b = 0; b < 16; b++) begin
            if (diff[b]) begin
                // Later iterations win, so highest mismatch decides
                if (b >= 8) begin
                    direction_o = nibble(dir_high_i, 3'(b - 8));
                end else begin
                    direction_o = nibble(dir_low_i, 3'(b));
                end
            end
        end
    end
endmodule

// [rtl/srdc_core.sv]
// Node configuration registers, route decision and debug line control
`timescale 1ns/100ps
module srdc_core
    import srdc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // Configuration access
    input  wire logic        cfg_valid_i,
    input  wire logic        cfg_write_i,
    input  wire logic [7:0]  cfg_num_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic [31:0]      cfg_rdata_o,
    // Route lookup
    input  wire logic        route_req_i,
    input  wire logic [15:0] route_dest_i,
    output logic             route_valid_o,
    output logic             route_local_o,
    output logic [3:0]       route_dir_o,
    // Reference clock enable
    output logic             ref_tick_o,
    // Debug
    input  wire logic [13:0] otp_user_code_i,
    input  wire logic [1:0]  core_halted_flag_i,
    output logic [1:0]       core_debug_req_o,
    input  wire logic        debug_pin_n_i,
    output logic             debug_pin_n_o,
    output logic             debug_pin_n_oe_o,
    // Link state
    input  wire logic [15:0] link_src_kind_i,
    input  wire logic [63:0] link_dest_num_i,
    input  wire logic [7:0]  link_junk_i,
    input  wire logic [7:0]  link_dst_busy_i,
    input  wire logic [7:0]  link_src_busy_i,
    output logic [31:0]      link_dir_o,
    output logic [15:0]      link_net_o
);
    typedef struct packed {
        logic [15:0]      ref_div;
        logic [15:0]      ref_cnt;
        logic             ref_tick;
        logic [15:0]      node_id;
        logic [31:0]      dir_low;
        logic [31:0]      dir_high;
        logic [1:0]       dbg_tile0;
        logic [1:0]       dbg_tile1;
        logic [2:0]       origin;
        logic             line_prev;
        logic [7:0][3:0]  ls_dir;
        logic [7:0][1:0]  ls_net;
        logic             ack;
        logic [31:0]      rdata;
        logic             rt_valid;
        logic             rt_local;
        logic [3:0]       rt_dir;
    } srdc_state_t;

    srdc_state_t s_q;
    srdc_state_t s_d;

    logic        rt_local;
    logic [3:0]  rt_dir;
    logic [1:0]  core_drive;
    logic        ext_assert;
    logic        line_level;
    logic        line_event;
    logic        wr;
    logic        rd;
    logic [2:0]  link_idx;
    logic        link_hit;

    function automatic logic [31:0] link_word(input srdc_state_t st, input logic [2:0] i,
                                              input logic [15:0] kind, input logic [63:0] dnum,
                                              input logic [7:0] junk, input logic [7:0] dbusy,
                                              input logic [7:0] sbusy);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SRDC_LS_KIND_LSB +: 2] = kind[{i, 1'b0} +: 2];
        if (dbusy[i] || sbusy[i]) begin
            w[SRDC_LS_DEST_LSB +: 8] = dnum[{i, 3'b000} +: 8];
        end
        w[SRDC_LS_DIR_LSB +: 4]  = st.ls_dir[i];
        w[SRDC_LS_NET_LSB +: 2]  = st.ls_net[i];
        w[SRDC_LS_JUNK_BIT]      = junk[i];
        w[SRDC_LS_DBUSY_BIT]     = dbusy[i];
        w[SRDC_LS_SBUSY_BIT]     = sbusy[i];
        link_word = w;
    endfunction

    srdc_route u_route (
        .node_id_i       (s_q.node_id),
        .dest_id_i       (route_dest_i),
        .dir_low_i       (s_q.dir_low),
        .dir_high_i      (s_q.dir_high),
        .deliver_local_o (rt_local),
        .direction_o     (rt_dir)
    );

    assign wr = cfg_valid_i && cfg_write_i;
    assign rd = cfg_valid_i && !cfg_write_i;
    assign link_idx = cfg_num_i[2:0];
    assign link_hit = (cfg_num_i[7:3] == SRDC_NUM_LINK_BASE[7:3]);

    // Shared halt line: low while asserted by the pin or by an enabled core
    assign core_drive[0] = s_q.dbg_tile0[SRDC_DBG_DRV_EN_BIT] && core_halted_flag_i[0];
    assign core_drive[1] = s_q.dbg_tile1[SRDC_DBG_DRV_EN_BIT] && core_halted_flag_i[1];
    assign ext_assert = !debug_pin_n_i && (core_drive == 2'b00);
    assign line_level = !debug_pin_n_i || (core_drive != 2'b00);
    assign line_event = line_level && !s_q.line_prev;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.line_prev = line_level;

        // Reference tick once every ref_div+1 cycles
        s_d.ref_tick = 1'b0;
        if (s_q.ref_cnt >= s_q.ref_div) begin
            s_d.ref_cnt  = 16'h0000;
            s_d.ref_tick = 1'b1;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
        end

        s_d.rt_valid = route_req_i;
        if (route_req_i) begin
            s_d.rt_local = rt_local;
            s_d.rt_dir   = rt_local ? 4'h0 : rt_dir;
        end

        if (cfg_valid_i) begin
            s_d.ack = 1'b1;
        end

        if (wr) begin
            case (cfg_num_i)
                SRDC_NUM_NODE_ID:    s_d.node_id  = cfg_wdata_i[15:0];
                SRDC_NUM_REF_CLK:    s_d.ref_div  = cfg_wdata_i[15:0];
                SRDC_NUM_DIR_LOW:    s_d.dir_low  = cfg_wdata_i;
                SRDC_NUM_DIR_HIGH:   s_d.dir_high = cfg_wdata_i;
                SRDC_NUM_DBG_TILE0:  s_d.dbg_tile0 = cfg_wdata_i[1:0];
                SRDC_NUM_DBG_TILE1:  s_d.dbg_tile1 = cfg_wdata_i[1:0];
                SRDC_NUM_DBG_ORIGIN: begin
                    s_d.origin = {cfg_wdata_i[SRDC_ORG_EXT_BIT],
                                  cfg_wdata_i[SRDC_ORG_CORE1_BIT],
                                  cfg_wdata_i[SRDC_ORG_CORE0_BIT]};
                end
                default: begin
                    if (link_hit) begin
                        s_d.ls_dir[link_idx] = cfg_wdata_i[SRDC_LS_DIR_LSB +: 4];
                        s_d.ls_net[link_idx] = cfg_wdata_i[SRDC_LS_NET_LSB +: 2];
                    end
                end
            endcase
        end

        // New debug event overrides a software write in the same cycle
        if (line_event) begin
            s_d.origin = {ext_assert, core_drive[1], core_drive[0]};
        end

        if (rd) begin
            case (cfg_num_i)
                SRDC_NUM_NODE_ID:    s_d.rdata = {16'h0000, s_q.node_id};
                SRDC_NUM_REF_CLK:    s_d.rdata = {16'h0000, s_q.ref_div};
                SRDC_NUM_JTAG_ID:    s_d.rdata = SRDC_JTAG_ID_WORD;
                SRDC_NUM_USER_CODE: begin
                    s_d.rdata = {otp_user_code_i, SRDC_METAL_ID_CODE};
                end
                SRDC_NUM_DIR_LOW:    s_d.rdata = s_q.dir_low;
                SRDC_NUM_DIR_HIGH:   s_d.rdata = s_q.dir_high;
                SRDC_NUM_DBG_TILE0:  s_d.rdata = {30'h0, s_q.dbg_tile0};
                SRDC_NUM_DBG_TILE1:  s_d.rdata = {30'h0, s_q.dbg_tile1};
                SRDC_NUM_DBG_ORIGIN: s_d.rdata = {27'h0, s_q.origin[2], 2'b00, s_q.origin[1:0]};
                default: begin
                    if (link_hit) begin
                        s_d.rdata = link_word(s_q, link_idx, link_src_kind_i, link_dest_num_i,
                                              link_junk_i, link_dst_busy_i, link_src_busy_i);
                    end else begin
                        s_d.rdata = 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q           <= '0;
            s_q.ref_div   <= SRDC_REF_DIV_RST;
            s_q.node_id   <= SRDC_NODE_ID_RST;
            s_q.dir_low   <= SRDC_DIR_RST;
            s_q.dir_high  <= SRDC_DIR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_ack_o        = s_q.ack;
    assign cfg_rdata_o      = s_q.rdata;
    assign route_valid_o    = s_q.rt_valid;
    assign route_local_o    = s_q.rt_local;
    assign route_dir_o      = s_q.rt_dir;
    assign ref_tick_o       = s_q.ref_tick;
    assign core_debug_req_o = {s_q.dbg_tile1[SRDC_DBG_REQ_EN_BIT] && line_level,
                               s_q.dbg_tile0[SRDC_DBG_REQ_EN_BIT] && line_level};
    assign debug_pin_n_o    = 1'b0;
    assign debug_pin_n_oe_o = (core_drive != 2'b00);
    assign link_dir_o       = s_q.ls_dir;
    assign link_net_o       = s_q.ls_net;

    property p_ref_write;
        @(posedge clock_i) disable iff (!nrst_i)
        (wr && cfg_num_i == SRDC_NUM_REF_CLK) |=> (s_q.ref_div == $past(cfg_wdata_i[15:0]));
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("divider not updated");

    property p_user_code;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && cfg_num_i == SRDC_NUM_USER_CODE) |=>
            (cfg_rdata_o == {$past(otp_user_code_i), SRDC_METAL_ID_CODE});
    endproperty
    a_user_code: assert property (p_user_code) else $error("user code word wrong");

    property p_route_local;
        @(posedge clock_i) disable iff (!nrst_i)
        (route_req_i && route_dest_i == s_q.node_id && !wr) |=> (route_valid_o && route_local_o);
    endproperty
    a_route_local: assert property (p_route_local) else $error("local match missed");

    property p_route_top_bit;
        @(posedge clock_i) disable iff (!nrst_i)
        (route_req_i && (route_dest_i[15] != s_q.node_id[15])) |=>
            (!route_local_o && route_dir_o == $past(s_q.dir_high[31:28]));
    endproperty
    a_route_top_bit: assert property (p_route_top_bit) else $error("bit 15 route wrong");

    property p_dbg_req;
        @(posedge clock_i) disable iff (!nrst_i)
        core_debug_req_o[0] == (s_q.dbg_tile0[1] && (!debug_pin_n_i || debug_pin_n_oe_o));
    endproperty
    a_dbg_req: assert property (p_dbg_req) else $error("debug request mismatch");

    property p_drive;
        @(posedge clock_i) disable iff (!nrst_i)
        (s_q.dbg_tile1[0] && core_halted_flag_i[1]) |-> debug_pin_n_oe_o;
    endproperty
    a_drive: assert property (p_drive) else $error("halted core not driving line");

    property p_ext_origin;
        @(posedge clock_i) disable iff (!nrst_i)
        (line_event && ext_assert) |=> (s_q.origin == 3'b100);
    endproperty
    a_ext_origin: assert property (p_ext_origin) else $error("external origin lost");

    property p_link_busy;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && link_hit) |=> (cfg_rdata_o[1:0] ==
            {$past(link_dst_busy_i[link_idx]), $past(link_src_busy_i[link_idx])});
    endproperty
    a_link_busy: assert property (p_link_busy) else $error("link busy bits wrong");

    property p_reserved;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && cfg_num_i == SRDC_NUM_NODE_ID) |=> (cfg_rdata_o[31:16] == 16'h0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_node_write;
        @(posedge clock_i) disable iff (!nrst_i)
        (wr && cfg_num_i == SRDC_NUM_NODE_ID) |=> (s_q.node_id == $past(cfg_wdata_i[15:0]));
    endproperty
    a_node_write: assert property (p_node_write) else $error("node id not updated");

    property p_dirl_write;
        @(posedge clock_i) disable iff (!nrst_i)
        (wr && cfg_num_i == SRDC_NUM_DIR_LOW) |=> (s_q.dir_low == $past(cfg_wdata_i));
    endproperty
    a_dirl_write: assert property (p_dirl_write) else $error("low table stale");

    property p_route_bit7;
        @(posedge clock_i) disable iff (!nrst_i)
        (route_req_i && route_dest_i[15:7] == (s_q.node_id[15:7] ^ 9'h001)) |=>
            (!route_local_o && route_dir_o == $past(s_q.dir_low[31:28]));
    endproperty
    a_route_bit7: assert property (p_route_bit7) else $error("bit 7 route wrong");

    property p_core_origin;
        @(posedge clock_i) disable iff (!nrst_i)
        (line_event && !ext_assert) |=> (s_q.origin == {1'b0, $past(core_drive)});
    endproperty
    a_core_origin: assert property (p_core_origin) else $error("core origin lost");

    property p_link_kind;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && link_hit) |=> (cfg_rdata_o[SRDC_LS_KIND_LSB +: 2] ==
            $past(link_src_kind_i[{link_idx, 1'b0} +: 2]));
    endproperty
    a_link_kind: assert property (p_link_kind) else $error("link kind wrong");

    property p_link_dest;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && link_hit && link_src_busy_i[link_idx]) |=>
            (cfg_rdata_o[SRDC_LS_DEST_LSB +: 8] ==
             $past(link_dest_num_i[{link_idx, 3'b000} +: 8]));
    endproperty
    a_link_dest: assert property (p_link_dest) else $error("link destination wrong");

    property p_link_junk;
        @(posedge clock_i) disable iff (!nrst_i)
        (rd && link_hit) |=> (cfg_rdata_o[SRDC_LS_JUNK_BIT] == $past(link_junk_i[link_idx]));
    endproperty
    a_link_junk: assert property (p_link_junk) else $error("link junk bit wrong");

    property p_link_dir;
        @(posedge clock_i) disable iff (!nrst_i)
        (wr && link_hit) |=>
            (s_q.ls_dir[$past(link_idx)] == $past(cfg_wdata_i[SRDC_LS_DIR_LSB +: 4]));
    endproperty
    a_link_dir: assert property (p_link_dir) else $error("link direction not updated");

    property p_ref_tick;
        @(posedge clock_i) disable iff (!nrst_i)
        (ref_tick_o && s_q.ref_div != 16'h0000) |=> !ref_tick_o;
    endproperty
    a_ref_tick: assert property (p_ref_tick) else $error("reference tick too long");
endmodule

// [tb/srdc_partner.sv]
// Far-side model: tiles, neighbour links and the pulled-up shared halt line
`timescale 1ns/100ps
module srdc_partner
    import srdc_pkg::*;
(
    // Bench control
    input  wire logic [1:0]  halt_req_i,
    input  wire logic        ext_low_i,
    input  wire logic        links_on_i,
    // Shared halt line
    input  wire logic        pin_drive_i,
    input  wire logic        pin_oe_i,
    output logic             debug_pin_n_o,
    output logic [1:0]       core_halted_flag_o,
    // Link state
    output logic [15:0]      link_src_kind_o,
    output logic [63:0]      link_dest_num_o,
    output logic [7:0]       link_junk_o,
    output logic [7:0]       link_dst_busy_o,
    output logic [7:0]       link_src_busy_o
);
    // Pull-up unless the block or the external pin pulls low
    assign debug_pin_n_o      = ~((pin_oe_i & ~pin_drive_i) | ext_low_i);
    assign core_halted_flag_o = halt_req_i;

    always_comb begin
        for (int i = 0; i < SRDC_LINKS; i++) begin
            link_src_kind_o[2*i +: 2] = 2'(i);
            link_dest_num_o[8*i +: 8] = 8'h10 + 8'(i);
            link_junk_o[i]            = links_on_i & i[2];
            link_dst_busy_o[i]        = links_on_i & i[1];
            link_src_busy_o[i]        = links_on_i & i[0];
        end
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the routing and debug configuration block
`timescale 1ns/100ps
module tb
    import srdc_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        nrst_i;
    logic        cfg_valid_i, cfg_write_i, cfg_ack_o, route_req_i, route_valid_o;
    logic        route_local_o, ref_tick_o, pin_n, pin_o, pin_oe, ext_low, links_on;
    logic [7:0]  cfg_num_i, junk, dbusy, sbusy;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, link_dir, ev;
    logic [15:0] route_dest_i, kind, link_net;
    logic [3:0]  route_dir_o, li;
    logic [1:0]  halted, dreq, halt_req;
    logic [63:0] dnum;
    logic [15:0] m;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          gap;

    always #2 clock_i = ~clock_i;

    srdc_core uut (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .cfg_valid_i(cfg_valid_i), .cfg_write_i(cfg_write_i), .cfg_num_i(cfg_num_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
        .route_req_i(route_req_i), .route_dest_i(route_dest_i),
        .route_valid_o(route_valid_o), .route_local_o(route_local_o),
        .route_dir_o(route_dir_o), .ref_tick_o(ref_tick_o),
        .otp_user_code_i(14'h2A5B), .core_halted_flag_i(halted),
        .core_debug_req_o(dreq), .debug_pin_n_i(pin_n), .debug_pin_n_o(pin_o),
        .debug_pin_n_oe_o(pin_oe), .link_src_kind_i(kind), .link_dest_num_i(dnum),
        .link_junk_i(junk), .link_dst_busy_i(dbusy), .link_src_busy_i(sbusy),
        .link_dir_o(link_dir), .link_net_o(link_net)
    );

    srdc_partner far (
        .halt_req_i(halt_req), .ext_low_i(ext_low), .links_on_i(links_on),
        .pin_drive_i(pin_o), .pin_oe_i(pin_oe), .debug_pin_n_o(pin_n),
        .core_halted_flag_o(halted), .link_src_kind_o(kind), .link_dest_num_o(dnum),
        .link_junk_o(junk), .link_dst_busy_o(dbusy), .link_src_busy_o(sbusy)
    );

    task automatic complete_run;
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic w, input logic [7:0] n, input logic [31:0] d);
        @(posedge clock_i);
        cfg_valid_i <= 1'b1;
        cfg_write_i <= w;
        cfg_num_i   <= n;
        cfg_wdata_i <= d;
        @(posedge clock_i);
        cfg_valid_i <= 1'b0;
        #1;
        chk({31'h0, cfg_ack_o}, 32'h1);
    endtask

    task automatic rd(input logic [7:0] n, input logic [31:0] e);
        cfg(1'b0, n, 32'h0);
        chk(cfg_rdata_o, e);
    endtask

    task automatic route(input logic [15:0] dst, input logic lc, input logic [3:0] dr);
        @(posedge clock_i);
        route_req_i  <= 1'b1;
        route_dest_i <= dst;
        @(posedge clock_i);
        route_req_i  <= 1'b0;
        #1;
        chk({27'h0, route_valid_o, route_local_o, route_dir_o}, {27'h0, 1'b1, lc, dr});
    endtask

    // Drive far-side conditions and let the halt line settle
    task automatic ctl(input logic [1:0] h, input logic e, input logic on);
        @(posedge clock_i);
        halt_req <= h;
        ext_low  <= e;
        links_on <= on;
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    task automatic wait_tick;
        gap = 0;
        do begin
            @(posedge clock_i);
            #1;
            gap++;
        end while (ref_tick_o !== 1'b1 && gap < 40);
    endtask

    initial begin
        nrst_i = 1'b0;
        {cfg_valid_i, cfg_write_i, route_req_i, ext_low, links_on} = '0;
        {cfg_num_i, cfg_wdata_i, route_dest_i, halt_req} = '0;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(SRDC_NUM_REF_CLK, 32'h3);
        rd(SRDC_NUM_NODE_ID, 32'h0);
        rd(SRDC_NUM_DIR_LOW, SRDC_DIR_RST);
        rd(SRDC_NUM_DIR_HIGH, SRDC_DIR_RST);
        rd(SRDC_NUM_DBG_TILE0, 32'h0);
        for (int i = 0; i < SRDC_LINKS; i++) begin
            li = 4'(i);
            rd(SRDC_NUM_LINK_BASE + 8'(i), {6'h0, li[1:0], 24'h0});
        end
        cfg(1'b1, SRDC_NUM_USER_CODE, 32'hFFFF_FFFF);
        rd(SRDC_NUM_USER_CODE, {14'h2A5B, SRDC_METAL_ID_CODE});
        cfg(1'b1, SRDC_NUM_JTAG_ID, 32'h0);
        rd(SRDC_NUM_JTAG_ID, SRDC_JTAG_ID_WORD);
        cfg(1'b1, SRDC_NUM_REF_CLK, 32'hFFFF_0002);
        rd(SRDC_NUM_REF_CLK, 32'h2);
        wait_tick();
        wait_tick();
        chk(32'(gap), 32'h3);
        cfg(1'b1, SRDC_NUM_DIR_LOW, 32'h7654_3210);
        cfg(1'b1, SRDC_NUM_DIR_HIGH, 32'hFEDC_BA98);
        rd(SRDC_NUM_DIR_LOW, 32'h7654_3210);
        rd(SRDC_NUM_DIR_HIGH, 32'hFEDC_BA98);
        cfg(1'b1, SRDC_NUM_NODE_ID, 32'hFFFF_A5C3);
        rd(SRDC_NUM_NODE_ID, 32'h0000_A5C3);
        route(16'hA5C3, 1'b1, 4'h0);
        for (int d = 0; d < 16; d++) begin
            // Lower bits also differ so only the top mismatch may steer
            m = 16'h1 << d;
            route(16'hA5C3 ^ m ^ (m - 16'h1), 1'b0, 4'(d));
        end
        cfg(1'b1, SRDC_NUM_DBG_TILE0, 32'hFFFF_FFFF);
        rd(SRDC_NUM_DBG_TILE0, 32'h3);
        cfg(1'b1, SRDC_NUM_DBG_TILE1, 32'h2);
        cfg(1'b1, SRDC_NUM_DBG_ORIGIN, 32'hFFFF_FFFF);
        rd(SRDC_NUM_DBG_ORIGIN, 32'h13);
        ctl(2'b01, 1'b0, 1'b0);
        chk({29'h0, pin_oe, dreq}, 32'h7);
        rd(SRDC_NUM_DBG_ORIGIN, 32'h1);
        ctl(2'b10, 1'b0, 1'b0);
        chk({29'h0, pin_oe, dreq}, 32'h0);
        ctl(2'b00, 1'b1, 1'b0);
        chk({29'h0, pin_oe, dreq}, 32'h3);
        rd(SRDC_NUM_DBG_ORIGIN, 32'h10);
        ctl(2'b00, 1'b0, 1'b0);
        cfg(1'b1, SRDC_NUM_DBG_TILE1, 32'h3);
        ctl(2'b10, 1'b0, 1'b0);
        rd(SRDC_NUM_DBG_ORIGIN, 32'h2);
        ctl(2'b00, 1'b0, 1'b1);
        for (int i = 0; i < SRDC_LINKS; i++) begin
            li = 4'(i);
            cfg(1'b1, SRDC_NUM_LINK_BASE + 8'(i), {20'hFFFFF, li, 2'b11, li[1:0], 4'hF});
            ev = {6'h0, li[1:0], (li[1] | li[0]) ? 8'h10 + 8'(i) : 8'h0, 4'h0, li,
                  2'h0, li[1:0], 1'b0, li[2], li[1], li[0]};
            rd(SRDC_NUM_LINK_BASE + 8'(i), ev);
        end
        chk(link_dir, 32'h7654_3210);
        chk({16'h0, link_net}, 32'h0000_E4E4);
        rd(8'h28, 32'h0);
        cfg(1'b1, 8'h06, 32'hFFFF_FFFF);
        rd(8'h06, 32'h0);
        complete_run();
    end
endmodule
